/* adcrb_defs.svh */
/*
  Constants of the converter control register bank: register offsets, field
  positions, reset values and serial frame counts. Assumes inclusion by bare name.
*/
// Overview of operation
// - Writing one to bit 0 at 00 resets all registers; bit self-clears.
// - Readback enable bit at 01 enters readback mode; cleared returns to normal.
// - Upper address gate in 01 blocks register F0 when zero, permits when one.
// - Pattern sync, soft or pin, acts only while sync enable in 02 is set.
// - Full 16-bit field at 0A holds the ramp pattern restart value.
// - Each channel sleep mask bit at one powers down its channel.
// - Light sleep bit enters fast-recovery power-down; clearing restores normal.
// - Deep sleep bit enters slower-recovery full power-down; clearing restores normal.
// - Sleep pin role: one makes pin give light sleep, zero deep sleep.
// - Each bit at 14 enables low-frequency noise suppression for its channel.
// - Bit 14 at 1C makes frame clock follow the programmed pattern.
// - Programmed frame waveform comes from the 14-bit field in 1C.
// - Address 23 holds the lower 16 bits of the random pattern seed.
// - Bits 15 to 9 of 24 hold the seed's upper seven bits.
// - Low byte of 24 swaps input polarity per channel when one.
// - One write updates every field of that register at once.
// - Each frame is 8 address then 16 data bits on rising clock, select low.
// - In readback mode writes are ignored except to address 1.
// - In readback mode address 1 reads as zero; others shift out 16 bits.
`ifndef ADCRB_DEFS_SVH
`define ADCRB_DEFS_SVH
`define ADCRB_OFS_SOFT_RESET   8'h00
`define ADCRB_OFS_READBACK     8'h01
`define ADCRB_OFS_ALIGN        8'h02
`define ADCRB_OFS_RAMP         8'h0a
`define ADCRB_OFS_SLEEP        8'h0f
`define ADCRB_OFS_LOW_FREQ_NOISE_SUPPRESSION         8'h14
`define ADCRB_OFS_FRAME        8'h1c
`define ADCRB_OFS_SEED_LO      8'h23
`define ADCRB_OFS_INV_SEED     8'h24
`define ADCRB_OFS_HIGH         8'hf0
`define ADCRB_BIT_SOFT_RESET   0
`define ADCRB_BIT_READBACK     0
`define ADCRB_BIT_UPPER_GATE   4
`define ADCRB_BIT_SYNC_EN      13
`define ADCRB_BIT_LIGHT        8
`define ADCRB_BIT_DEEP         9
`define ADCRB_BIT_ROLE         10
`define ADCRB_BIT_OVERRIDE     14
`define ADCRB_BIT_SEED_HI_LSB  9
`define ADCRB_RST_BIT          1'b0
`define ADCRB_RST_WORD         16'h0000
`define ADCRB_RST_MASK         8'h00
`define ADCRB_RST_FRAME_BITS   14'h0000
`define ADCRB_RST_SEED         23'h000000
`define ADCRB_CNT_ADDR_LAST    5'h07
`define ADCRB_CNT_SHIFT_FIRST  5'h09
`define ADCRB_CNT_FRAME_LAST   5'h17
`define ADCRB_FRAME_TOP        4'hd
`endif

/* adcrb_pkg.sv */
/*
  Types of the converter control register bank: serial state and the
  configuration struct. Assumes nothing of its surroundings.
*/
package adcrb_pkg;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } adcrb_state_e;

  typedef struct packed {
    logic        readback_en;
    logic        upper_address_gate;
    logic        sync_enable;
    logic [15:0] ramp_start_value;
    logic [7:0]  channel_sleep_mask;
    logic        light_sleep_bit;
    logic        deep_sleep_bit;
    logic        sleep_pin_role;
    logic [7:0]  low_freq_noise_suppress_mask;
    logic        frame_waveform_override;
    logic [13:0] frame_waveform_bits;
    logic [22:0] random_pattern_seed;
    logic [7:0]  input_polarity_swap_mask;
    logic [15:0] high_reg;
  } adcrb_cfg_s;
endpackage

/* adcrb_bank.sv */
/*
  Control register bank of an eight-channel converter, loaded over a
  three-wire serial port, with serial readback, sleep control, pattern sync
  gating and a programmable frame clock. Assumes the serial pins come from
  outside the core_clk domain and that the serial clock stays well below
  core_clk so that each level survives three samples.
*/
`timescale 1ns/100ps
`default_nettype none
`include "adcrb_defs.svh"
module adcrb_bank #(
  parameter int N_CH = 8
) (
  input  wire logic               core_clk,
  input  wire logic               rst,
  input  wire logic               cs_n_pin,
  input  wire logic               sclk_pin,
  input  wire logic               serial_write_in,
  output var  logic               serial_readback_out,
  output var  logic               serial_readback_out_oe,
  input  wire logic               sleep_pin,
  input  wire logic               ext_sync_pin,
  input  wire logic               sw_sync_req,
  input  wire logic               frame_tick,
  input  wire logic               normal_frame_level,
  output var  adcrb_pkg::adcrb_cfg_s cfg_o,
  output var  logic               light_sleep_active,
  output var  logic               deep_sleep_active,
  output var  logic               pattern_sync,
  output var  logic               frame_clock_out_p,
  output var  logic               frame_clock_out_n
);
  // Pin vector: 0 select, 1 serial clock, 2 write data, 3 sleep pin, 4 sync pin
  localparam logic [4:0] PIN_IDLE = 5'h01;

  if (N_CH != 8) begin : g_bad_ch
    $error("adcrb_bank serves exactly eight channels");
  end

  function automatic adcrb_pkg::adcrb_cfg_s fn_default();
    adcrb_pkg::adcrb_cfg_s c;
    c.readback_en                  = `ADCRB_RST_BIT;
    c.upper_address_gate           = `ADCRB_RST_BIT;
    c.sync_enable                  = `ADCRB_RST_BIT;
    c.ramp_start_value             = `ADCRB_RST_WORD;
    c.channel_sleep_mask           = `ADCRB_RST_MASK;
    c.light_sleep_bit              = `ADCRB_RST_BIT;
    c.deep_sleep_bit               = `ADCRB_RST_BIT;
    c.sleep_pin_role               = `ADCRB_RST_BIT;
    c.low_freq_noise_suppress_mask = `ADCRB_RST_MASK;
    c.frame_waveform_override      = `ADCRB_RST_BIT;
    c.frame_waveform_bits          = `ADCRB_RST_FRAME_BITS;
    c.random_pattern_seed          = `ADCRB_RST_SEED;
    c.input_polarity_swap_mask     = `ADCRB_RST_MASK;
    c.high_reg                     = `ADCRB_RST_WORD;
    return c;
  endfunction

  function automatic logic [15:0] fn_read(input adcrb_pkg::adcrb_cfg_s c,
                                          input logic [7:0] a);
    logic [15:0] r;
    r = 16'h0000;
    if (a == `ADCRB_OFS_ALIGN) begin
      r[`ADCRB_BIT_SYNC_EN] = c.sync_enable;
    end else if (a == `ADCRB_OFS_RAMP) begin
      r = c.ramp_start_value;
    end else if (a == `ADCRB_OFS_SLEEP) begin
      r = {5'h00, c.sleep_pin_role, c.deep_sleep_bit, c.light_sleep_bit,
           c.channel_sleep_mask};
    end else if (a == `ADCRB_OFS_LOW_FREQ_NOISE_SUPPRESSION) begin
      r = {8'h00, c.low_freq_noise_suppress_mask};
    end else if (a == `ADCRB_OFS_FRAME) begin
      r = {1'b0, c.frame_waveform_override, c.frame_waveform_bits};
    end else if (a == `ADCRB_OFS_SEED_LO) begin
      r = c.random_pattern_seed[15:0];
    end else if (a == `ADCRB_OFS_INV_SEED) begin
      r = {c.random_pattern_seed[22:16], 1'b0, c.input_polarity_swap_mask};
    end else if (a == `ADCRB_OFS_HIGH && c.upper_address_gate) begin
      r = c.high_reg;
    end
    return r;
  endfunction

  logic [4:0]              sync1_q;
  logic [4:0]              sync2_q;
  logic [4:0]              sync3_q;
  logic [4:0]              lvl_q;
  logic [4:0]              lvl_d;
  logic                    cs_active;
  logic                    sclk_rise;
  logic                    sclk_fall;
  logic                    serial_write_in_bit;
  logic                    ext_sync_rise;
  adcrb_pkg::adcrb_state_e state_q;
  logic [4:0]              cnt_q;
  logic [22:0]             shift_q;
  logic [23:0]             frame_w;
  logic [7:0]              addr_w;
  logic [15:0]             data_w;
  logic                    commit;
  logic                    wr_ok;
  logic                    soft_rst;
  logic                    rd_load;
  logic [7:0]              rd_addr_w;
  logic [15:0]             rd_q;
  adcrb_pkg::adcrb_cfg_s   cfg_q;
  logic                    light_q;
  logic                    deep_q;
  logic                    sync_pulse_q;
  logic [3:0]              idx_q;
  logic                    frame_p_q;
  logic                    frame_n_q;

  // Three-stage capture; a level counts only once stages two and three agree
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_q <= PIN_IDLE;
      sync2_q <= PIN_IDLE;
      sync3_q <= PIN_IDLE;
      lvl_q   <= PIN_IDLE;
    end else begin
      sync1_q <= {ext_sync_pin, sleep_pin, serial_write_in, sclk_pin, cs_n_pin};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      lvl_q   <= lvl_d;
    end
  end

  always_comb begin
    lvl_d = (sync2_q & sync3_q) | (lvl_q & (sync2_q ^ sync3_q));
  end

  assign cs_active     = ~lvl_d[0];
  assign sclk_rise     = lvl_d[1] & ~lvl_q[1];
  assign sclk_fall     = ~lvl_d[1] & lvl_q[1];
  assign serial_write_in_bit     = lvl_d[2];
  assign ext_sync_rise = lvl_d[4] & ~lvl_q[4];

  // A serial clock edge in the same cycle as select falling is not counted;
  // the select setup time keeps that case out of legal traffic.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= adcrb_pkg::ST_IDLE;
      cnt_q   <= 5'h00;
      shift_q <= 23'h000000;
    end else begin
      case (state_q)
        adcrb_pkg::ST_IDLE: begin
          cnt_q <= 5'h00;
          if (cs_active) begin
            state_q <= adcrb_pkg::ST_SHIFT;
          end
        end
        adcrb_pkg::ST_SHIFT: begin
          if (!cs_active) begin
            // A partial frame is dropped here
            state_q <= adcrb_pkg::ST_IDLE;
            cnt_q   <= 5'h00;
          end else if (sclk_rise) begin
            shift_q <= {shift_q[21:0], serial_write_in_bit};
            cnt_q   <= (cnt_q == `ADCRB_CNT_FRAME_LAST) ? 5'h00 : cnt_q + 5'h01;
          end
        end
        default: begin
          state_q <= adcrb_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign frame_w   = {shift_q, serial_write_in_bit};
  assign addr_w    = frame_w[23:16];
  assign data_w    = frame_w[15:0];
  assign commit    = (state_q == adcrb_pkg::ST_SHIFT) & cs_active & sclk_rise &
                     (cnt_q == `ADCRB_CNT_FRAME_LAST);
  assign wr_ok     = commit & (~cfg_q.readback_en | (addr_w == `ADCRB_OFS_READBACK));
  assign soft_rst  = wr_ok & (addr_w == `ADCRB_OFS_SOFT_RESET) &
                     data_w[`ADCRB_BIT_SOFT_RESET];
  assign rd_load   = (state_q == adcrb_pkg::ST_SHIFT) & cs_active & sclk_rise &
                     (cnt_q == `ADCRB_CNT_ADDR_LAST);
  assign rd_addr_w = {shift_q[6:0], serial_write_in_bit};

  // Register file; the reset bit itself is never stored, so it reads zero
  always_ff @(posedge core_clk) begin
    if (rst || soft_rst) begin
      cfg_q <= fn_default();
    end else if (wr_ok) begin
      if (addr_w == `ADCRB_OFS_READBACK) begin
        cfg_q.readback_en        <= data_w[`ADCRB_BIT_READBACK];
        cfg_q.upper_address_gate <= data_w[`ADCRB_BIT_UPPER_GATE];
      end else if (addr_w == `ADCRB_OFS_ALIGN) begin
        cfg_q.sync_enable <= data_w[`ADCRB_BIT_SYNC_EN];
      end else if (addr_w == `ADCRB_OFS_RAMP) begin
        cfg_q.ramp_start_value <= data_w;
      end else if (addr_w == `ADCRB_OFS_SLEEP) begin
        cfg_q.channel_sleep_mask <= data_w[7:0];
        cfg_q.light_sleep_bit    <= data_w[`ADCRB_BIT_LIGHT];
        cfg_q.deep_sleep_bit     <= data_w[`ADCRB_BIT_DEEP];
        cfg_q.sleep_pin_role     <= data_w[`ADCRB_BIT_ROLE];
      end else if (addr_w == `ADCRB_OFS_LOW_FREQ_NOISE_SUPPRESSION) begin
        cfg_q.low_freq_noise_suppress_mask <= data_w[7:0];
      end else if (addr_w == `ADCRB_OFS_FRAME) begin
        cfg_q.frame_waveform_override <= data_w[`ADCRB_BIT_OVERRIDE];
        cfg_q.frame_waveform_bits     <= data_w[13:0];
      end else if (addr_w == `ADCRB_OFS_SEED_LO) begin
        cfg_q.random_pattern_seed[15:0] <= data_w;
      end else if (addr_w == `ADCRB_OFS_INV_SEED) begin
        cfg_q.random_pattern_seed[22:16] <= data_w[15:`ADCRB_BIT_SEED_HI_LSB];
        cfg_q.input_polarity_swap_mask   <= data_w[7:0];
      end else if (addr_w == `ADCRB_OFS_HIGH && cfg_q.upper_address_gate) begin
        cfg_q.high_reg <= data_w;
      end
      // Any other address falls through with no effect
    end
  end

  // Readout word is loaded on the last address edge so its top bit stands
  // for the first data edge; later bits advance on falling edges.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_q <= 16'h0000;
    end else if (rd_load) begin
      rd_q <= (rd_addr_w == `ADCRB_OFS_READBACK) ? 16'h0000 : fn_read(cfg_q, rd_addr_w);
    end else if ((state_q == adcrb_pkg::ST_SHIFT) && cs_active && sclk_fall &&
                 (cnt_q >= `ADCRB_CNT_SHIFT_FIRST)) begin
      rd_q <= {rd_q[14:0], 1'b0};
    end
  end

  assign serial_readback_out    = rd_q[15];
  assign serial_readback_out_oe = cfg_q.readback_en;
  assign cfg_o                  = cfg_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      light_q <= 1'b0;
      deep_q  <= 1'b0;
    end else begin
      light_q <= cfg_q.light_sleep_bit | (lvl_q[3] & cfg_q.sleep_pin_role);
      deep_q  <= cfg_q.deep_sleep_bit | (lvl_q[3] & ~cfg_q.sleep_pin_role);
    end
  end

  assign light_sleep_active = light_q;
  assign deep_sleep_active  = deep_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_pulse_q <= 1'b0;
    end else begin
      sync_pulse_q <= cfg_q.sync_enable & (sw_sync_req | ext_sync_rise);
    end
  end

  assign pattern_sync = sync_pulse_q;

  // Pattern is sent top bit first, one bit per frame tick, then repeats
  always_ff @(posedge core_clk) begin
    if (rst) begin
      idx_q     <= `ADCRB_FRAME_TOP;
      frame_p_q <= 1'b0;
      frame_n_q <= 1'b1;
    end else if (frame_tick) begin
      if (cfg_q.frame_waveform_override) begin
        frame_p_q <= cfg_q.frame_waveform_bits[idx_q];
        frame_n_q <= ~cfg_q.frame_waveform_bits[idx_q];
        idx_q     <= (idx_q == 4'h0) ? `ADCRB_FRAME_TOP : idx_q - 4'h1;
      end else begin
        frame_p_q <= normal_frame_level;
        frame_n_q <= ~normal_frame_level;
        idx_q     <= `ADCRB_FRAME_TOP;
      end
    end
  end

  assign frame_clock_out_p = frame_p_q;
  assign frame_clock_out_n = frame_n_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_soft_reset;
    soft_rst |=> (cfg_q == fn_default()) && !serial_readback_out_oe;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset left state");

  property p_readback_set;
    wr_ok && (addr_w == `ADCRB_OFS_READBACK) |=>
      serial_readback_out_oe == $past(data_w[0]);
  endproperty
  a_readback_set: assert property (p_readback_set) else $error("readback bit wrong");

  property p_high_gate;
    commit && (addr_w == `ADCRB_OFS_HIGH) && !cfg_q.upper_address_gate |=>
      $stable(cfg_q.high_reg);
  endproperty
  a_high_gate: assert property (p_high_gate) else $error("gated register written");

  property p_sync_gate;
    pattern_sync |-> $past(cfg_q.sync_enable);
  endproperty
  a_sync_gate: assert property (p_sync_gate) else $error("sync while disabled");

  property p_ramp;
    wr_ok && (addr_w == `ADCRB_OFS_RAMP) |=> cfg_q.ramp_start_value == $past(data_w);
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp value not stored");

  property p_sleep_word;
    wr_ok && (addr_w == `ADCRB_OFS_SLEEP) |=>
      (cfg_q.channel_sleep_mask == $past(data_w[7:0])) &&
      (cfg_q.deep_sleep_bit == $past(data_w[9])) ##1
      (deep_sleep_active == ($past(cfg_q.deep_sleep_bit) |
                             ($past(lvl_q[3]) & ~$past(cfg_q.sleep_pin_role))));
  endproperty
  a_sleep_word: assert property (p_sleep_word) else $error("sleep word mismatch");

  property p_pin_role;
    lvl_q[3] && cfg_q.sleep_pin_role |=> light_sleep_active;
  endproperty
  a_pin_role: assert property (p_pin_role) else $error("pin role ignored");

  property p_read_only;
    commit && cfg_q.readback_en && (addr_w != `ADCRB_OFS_READBACK) |=> $stable(cfg_q);
  endproperty
  a_read_only: assert property (p_read_only) else $error("write in readback");

  property p_hide_one;
    rd_load && (rd_addr_w == `ADCRB_OFS_READBACK) |=> (rd_q == 16'h0000);
  endproperty
  a_hide_one: assert property (p_hide_one) else $error("address 1 returned");

  property p_frame_pat;
    frame_tick && cfg_q.frame_waveform_override |=>
      frame_clock_out_p == $past(cfg_q.frame_waveform_bits[idx_q]) &&
      frame_clock_out_n != frame_clock_out_p;
  endproperty
  a_frame_pat: assert property (p_frame_pat) else $error("frame pattern wrong");

  c_soft_reset: cover property (soft_rst);
  c_readback:   cover property (rd_load && cfg_q.readback_en);
  c_high_write: cover property (wr_ok && (addr_w == `ADCRB_OFS_HIGH) && cfg_q.upper_address_gate);
  c_sync:       cover property (pattern_sync);
endmodule // adcrb_bank
`default_nettype wire

/* adcrb_ctrl_model.sv */
/*
  Behavioural serial controller that programs and reads the converter
  register bank over the three-wire port. Assumes core_clk paces it and
  that the bench calls xfer from a single process.
*/
`timescale 1ns/100ps
`default_nettype none
module adcrb_ctrl_model (
  input  wire logic core_clk,
  output var  logic cs_n_pin,
  output var  logic sclk_pin,
  output var  logic serial_write_in,
  input  wire logic serial_readback_out,
  input  wire logic serial_readback_out_oe
);
  // Eight core cycles a level keeps every level past the pin synchroniser
  localparam int HALF = 8;
  logic last_q = 1'b0;
  wire  line;
  // A released readback pin shows the inverse of its last level, never a held copy
  assign line = serial_readback_out_oe ? serial_readback_out : ~last_q;
  always @(posedge core_clk) begin
    if (serial_readback_out_oe) last_q <= serial_readback_out;
  end
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    serial_write_in = 1'b0;
  end
  task automatic xfer(input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
    logic [23:0] w;
    w = {a, d};
    q = 16'h0000;
    @(posedge core_clk) cs_n_pin <= 1'b0;
    repeat (HALF) @(posedge core_clk);
    for (int i = 23; i >= 0; i--) begin
      serial_write_in <= w[i];
      repeat (HALF) @(posedge core_clk);
      sclk_pin <= 1'b1;
      if (i < 16) q = {q[14:0], line};
      repeat (HALF) @(posedge core_clk);
      sclk_pin <= 1'b0;
    end
    repeat (HALF) @(posedge core_clk);
    cs_n_pin <= 1'b1;
    repeat (2 * HALF) @(posedge core_clk);
  endtask
  // Raises select after nb bits, so the bank has to discard the partial word
  task automatic cut(input logic [23:0] w, input int nb);
    @(posedge core_clk) cs_n_pin <= 1'b0;
    repeat (HALF) @(posedge core_clk);
    for (int i = 23; i > 23 - nb; i--) begin
      serial_write_in <= w[i];
      repeat (HALF) @(posedge core_clk);
      sclk_pin <= 1'b1;
      repeat (HALF) @(posedge core_clk);
      sclk_pin <= 1'b0;
    end
    repeat (HALF) @(posedge core_clk);
    cs_n_pin <= 1'b1;
    repeat (2 * HALF) @(posedge core_clk);
  endtask
endmodule // adcrb_ctrl_model
`default_nettype wire

/* adcrb_bank_tb_top.sv */
/*
  Self-checking bench of the converter register bank: random and corner
  register traffic, readback, sleep, sync and frame clock. Assumes the
  serial controller model drives the three-wire port.
*/
`timescale 1ns/100ps
`default_nettype none
module adcrb_bank_tb_top;
  logic                  core_clk = 1'b0;
  logic                  rst = 1'b1;
  logic                  sleep_pin = 1'b0;
  logic                  ext_sync_pin = 1'b0;
  logic                  sw_sync_req = 1'b0;
  logic                  frame_tick = 1'b0;
  logic                  normal_frame_level = 1'b0;
  wire                   cs_n_pin;
  wire                   sclk_pin;
  wire                   serial_write_in;
  logic                  serial_readback_out;
  logic                  serial_readback_out_oe;
  logic                  light_sleep_active;
  logic                  deep_sleep_active;
  logic                  pattern_sync;
  logic                  frame_clock_out_p;
  logic                  frame_clock_out_n;
  adcrb_pkg::adcrb_cfg_s cfg_o;
  adcrb_pkg::adcrb_cfg_s exp_cfg = '0;
  int                    miscompares = 0;
  int                    n_tests = 0;
  int                    cycles = 0;
  int                    n;
  integer                seed = 32'h3eec85eb;
  logic [15:0]           q;
  logic [15:0]           d;
  logic [13:0]           pat;
  logic [7:0]            a;
  logic [2:0]            s;
  logic                  p;
  logic                  b;
  logic                  nl;
  logic [7:0]            addrs [7] = '{8'h02, 8'h0a, 8'h0f, 8'h14, 8'h1c, 8'h23, 8'h24};

  always #20 core_clk = ~core_clk;

  adcrb_bank i_dut (
    .core_clk(core_clk), .rst(rst), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .serial_write_in(serial_write_in), .serial_readback_out(serial_readback_out),
    .serial_readback_out_oe(serial_readback_out_oe), .sleep_pin(sleep_pin),
    .ext_sync_pin(ext_sync_pin), .sw_sync_req(sw_sync_req), .frame_tick(frame_tick),
    .normal_frame_level(normal_frame_level), .cfg_o(cfg_o),
    .light_sleep_active(light_sleep_active), .deep_sleep_active(deep_sleep_active),
    .pattern_sync(pattern_sync), .frame_clock_out_p(frame_clock_out_p),
    .frame_clock_out_n(frame_clock_out_n)
  );

  adcrb_ctrl_model i_ctrl (
    .core_clk(core_clk), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .serial_write_in(serial_write_in), .serial_readback_out(serial_readback_out),
    .serial_readback_out_oe(serial_readback_out_oe)
  );

  // Defined bits only, so unassigned positions always go out as zero
  function automatic logic [15:0] dmask(input logic [7:0] ad);
    case (ad)
      8'h02: return 16'h2000;
      8'h0f: return 16'h07ff;
      8'h14: return 16'h00ff;
      8'h1c: return 16'h7fff;
      8'h24: return 16'hfeff;
      default: return 16'hffff;
    endcase
  endfunction

  function automatic adcrb_pkg::adcrb_cfg_s apply(adcrb_pkg::adcrb_cfg_s c, logic [7:0] ad,
                                                  logic [15:0] dd);
    if (c.readback_en && ad != 8'h01) return c;
    case (ad)
      8'h00: if (dd[0]) c = '0;
      8'h01: {c.upper_address_gate, c.readback_en} = {dd[4], dd[0]};
      8'h02: c.sync_enable = dd[13];
      8'h0a: c.ramp_start_value = dd;
      8'h0f: {c.sleep_pin_role, c.deep_sleep_bit, c.light_sleep_bit,
              c.channel_sleep_mask} = dd[10:0];
      8'h14: c.low_freq_noise_suppress_mask = dd[7:0];
      8'h1c: {c.frame_waveform_override, c.frame_waveform_bits} = dd[14:0];
      8'h23: c.random_pattern_seed[15:0] = dd;
      8'h24: {c.random_pattern_seed[22:16], c.input_polarity_swap_mask} = {dd[15:9], dd[7:0]};
      8'hf0: if (c.upper_address_gate) c.high_reg = dd;
      default: ;
    endcase
    return c;
  endfunction

  function automatic logic [15:0] rdexp(adcrb_pkg::adcrb_cfg_s c, logic [7:0] ad);
    case (ad)
      8'h02: return {2'b00, c.sync_enable, 13'h0000};
      8'h0a: return c.ramp_start_value;
      8'h0f: return {5'h00, c.sleep_pin_role, c.deep_sleep_bit, c.light_sleep_bit,
                     c.channel_sleep_mask};
      8'h14: return {8'h00, c.low_freq_noise_suppress_mask};
      8'h1c: return {1'b0, c.frame_waveform_override, c.frame_waveform_bits};
      8'h23: return c.random_pattern_seed[15:0];
      8'h24: return {c.random_pattern_seed[22:16], 1'b0, c.input_polarity_swap_mask};
      8'hf0: return c.upper_address_gate ? c.high_reg : 16'h0000;
      default: return 16'h0000;
    endcase
  endfunction

  task automatic chk(input logic [127:0] got, input logic [127:0] want);
    n_tests++;
    if (got !== want) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
    end
  endtask

  task automatic xf(input logic [7:0] ad, input logic [15:0] dd);
    logic [15:0] want;
    logic        rb;
    want = rdexp(exp_cfg, ad);
    rb = exp_cfg.readback_en;
    i_ctrl.xfer(ad, dd, q);
    exp_cfg = apply(exp_cfg, ad, dd);
    if (rb) chk(q, want);
    chk(cfg_o, exp_cfg);
    chk(serial_readback_out_oe, exp_cfg.readback_en);
  endtask

  task automatic give_verdict;
    $display("comparisons=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Ceiling sits well above the roughly 25k cycles the sequence needs
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    chk(cfg_o, 128'h0);
    chk({frame_clock_out_p, frame_clock_out_n, light_sleep_active, deep_sleep_active},
        4'b0100);
    for (int i = 0; i < 24; i++) begin
      a = addrs[$unsigned($random(seed)) % 7];
      d = 16'($random(seed));
      xf(a, d & dmask(a));
    end
    xf(8'h0a, 16'hffff);
    xf(8'h30, 16'hffff);
    xf(8'h0a, 16'h0000);
    i_ctrl.cut({8'h0a, 16'h1234}, 23);
    chk(cfg_o, exp_cfg);
    xf(8'hf0, 16'ha5c3);
    xf(8'h01, 16'h0010);
    xf(8'hf0, 16'ha5c3);
    xf(8'h01, 16'h0011);
    for (int i = 0; i < 7; i++) xf(addrs[i], 16'($random(seed)) & dmask(addrs[i]));
    xf(8'hf0, 16'h0000);
    xf(8'h00, 16'h0001);
    xf(8'h01, 16'h0011);
    xf(8'h01, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      s = i[2:0];
      xf(8'h0f, {5'h00, s, 8'h5a});
      for (int j = 0; j < 2; j++) begin
        p = j[0];
        @(posedge core_clk) sleep_pin <= p;
        repeat (8) @(posedge core_clk);
        chk({light_sleep_active, deep_sleep_active},
            {s[0] | (p & s[2]), s[1] | (p & ~s[2])});
      end
      @(posedge core_clk) sleep_pin <= 1'b0;
    end
    for (int k = 0; k < 2; k++) begin
      xf(8'h02, k[0] ? 16'h2000 : 16'h0000);
      @(posedge core_clk) sw_sync_req <= 1'b1;
      @(posedge core_clk) sw_sync_req <= 1'b0;
      #1 chk(pattern_sync, k[0]);
      n = 0;
      @(posedge core_clk) ext_sync_pin <= 1'b1;
      repeat (10) begin
        @(posedge core_clk);
        #1 n += (pattern_sync === 1'b1);
      end
      @(posedge core_clk) ext_sync_pin <= 1'b0;
      chk(n, k);
    end
    pat = 14'($random(seed));
    for (int k = 0; k < 2; k++) begin
      xf(8'h1c, k[0] ? {2'b01, pat} : 16'h0000);
      for (int j = 0; j < 28; j++) begin
        nl = 1'($random(seed));
        @(posedge core_clk);
        frame_tick <= 1'b1;
        normal_frame_level <= nl;
        @(posedge core_clk);
        frame_tick <= 1'b0;
        b = k[0] ? pat[13 - (j % 14)] : nl;
        #1 chk({frame_clock_out_p, frame_clock_out_n}, {b, ~b});
      end
    end
    xf(8'h00, 16'h0001);
    xf(8'h0a, 16'hbeef);
    xf(8'h00, 16'h0000);
    give_verdict();
  end
endmodule // adcrb_bank_tb_top
`default_nettype wire
